// ---- shared/fieldbus_message_handshake_consts.svh ----
// constants for the fieldbus message handshake block: offsets, fields, resets, timing
`ifndef FIELDBUS_MESSAGE_HANDSHAKE_CONSTS_SVH
`define FIELDBUS_MESSAGE_HANDSHAKE_CONSTS_SVH

// message window in the cyclic data images
`define MSG_BASE_OFS 5'h10
`define HSK_OFS 5'h1f
`define HSK_IDX 4'hf
`define RESP_LAST_IDX 4'he
`define CMD_LEN 4'hc

// handshake byte fields
`define HSK_TOGGLE_BIT 7
`define HSK_CLEAR_BIT 0
`define HSK_RESET 8'h00

// function codes
`define FC_READ 8'h03
`define FC_WRITE 8'h10
`define FC_ERR_FLAG 8'h80
`define ERR_ITEM_COUNT 8'h02
`define ERR_CODE_FUNC 8'h01
`define ERR_CODE_COUNT 8'h03

// timing
`define CLK_PERIOD_NS 10
`define ALIVE_PERIOD_MS 64
`define ALIVE_TICKS ((`ALIVE_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ---- shared/fieldbus_message_handshake_pkg.sv ----
// types for the fieldbus message handshake block
package fieldbus_message_handshake_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_SEND  = 3'b010,
    ST_WAIT  = 3'b011,
    ST_RECV  = 3'b100,
    ST_DONE  = 3'b101
  } state_e;

  typedef struct packed {
    state_e state;
    logic handshake_toggle_out;
    logic clear;
    logic toggle_seen;
    logic handshake_toggle_in;
    logic [3:0] alive_counter;
    logic [31:0] tick;
    logic [3:0] idx;
    logic [1:0] word;
    logic [11:0][7:0] cmd;
    logic [3:0][15:0] rd_words;
    logic err;
    logic [7:0] err_code;
    logic drv_req;
    logic drv_write;
    logic [15:0] drv_reg;
    logic [15:0] drv_wdata;
  } hsk_state_s;

endpackage

// ---- verilog/msg_byte_store.sv ----
// small byte memory with one write port and a registered read port
`timescale 1ns/1ps
module msg_byte_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // storage has no reset; only the read register is cleared
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // read data always comes out of a flip-flop
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

// ---- verilog/fieldbus_message_handshake.sv ----
// toggle-bit mailbox that turns cyclic command bytes into drive register accesses
`timescale 1ns/1ps
`include "fieldbus_message_handshake_consts.svh"
module fieldbus_message_handshake #(
  parameter int ALIVE_TICKS = `ALIVE_TICKS
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // cyclic output image from master, byte writes
  input wire logic out_wr_i,
  input wire logic [4:0] out_addr_i,
  input wire logic [7:0] out_data_i,
  // cyclic input image to master, registered byte reads
  input wire logic [4:0] in_addr_i,
  output logic [7:0] in_data_o,
  // drive register access port
  output logic drv_req_o,
  output logic drv_write_o,
  output logic [15:0] drv_reg_o,
  output logic [15:0] drv_wdata_o,
  input wire logic drv_ack_i,
  input wire logic drv_err_i,
  input wire logic [7:0] drv_err_code_i,
  input wire logic [15:0] drv_rdata_i
);

  fieldbus_message_handshake_pkg::hsk_state_s s;
  fieldbus_message_handshake_pkg::hsk_state_s n;

  logic cmd_wr;
  logic [7:0] cmd_rd_data;
  logic resp_wr;
  logic [3:0] resp_addr;
  logic [7:0] resp_data;
  logic hs_eff;
  logic [2:0] nwords;
  logic fc_ok;
  logic cnt_ok;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte lies inside the message window of an image
  function automatic logic in_window(input logic [4:0] addr);
    in_window = (addr >= `MSG_BASE_OFS);
  endfunction

  // exchange status code from the sequencer state
  function automatic logic [1:0] status_of(input fieldbus_message_handshake_pkg::state_e st);
    case (st)
      fieldbus_message_handshake_pkg::ST_FETCH: status_of = 2'h1;
      fieldbus_message_handshake_pkg::ST_SEND: status_of = 2'h1;
      fieldbus_message_handshake_pkg::ST_WAIT: status_of = 2'h2;
      fieldbus_message_handshake_pkg::ST_RECV: status_of = 2'h3;
      default: status_of = 2'h0;
    endcase
  endfunction

  // response byte at a given index of the message window
  function automatic logic [7:0] resp_byte(input fieldbus_message_handshake_pkg::hsk_state_s st,
                                           input logic [3:0] idx);
    logic [1:0] k;
    k = 2'(idx - 4'h4 >> 1);
    resp_byte = 8'h00;
    case (idx)
      4'h0: resp_byte = st.err ? (st.cmd[0] | `FC_ERR_FLAG) : st.cmd[0];
      4'h1: resp_byte = st.err ? 8'h00 : st.cmd[1];
      4'h2: resp_byte = st.err ? 8'h00 : st.cmd[2];
      4'h3: resp_byte = st.err ? `ERR_ITEM_COUNT : st.cmd[3];
      4'h5: resp_byte = st.err ? st.err_code : 8'h00;
      default: resp_byte = 8'h00;
    endcase
    // read data only; writes leave the data bytes zero, errors put the error code in byte 5
    if (!st.err && st.cmd[0] == `FC_READ && idx >= 4'h4 && idx <= 4'hb &&
        {1'b0, k} < st.cmd[3][3:1]) begin
      resp_byte = idx[0] ? st.rd_words[k][7:0] : st.rd_words[k][15:8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // message byte stores

  // command bytes land here; the handshake byte is decoded, not stored
  assign cmd_wr = out_wr_i && in_window(out_addr_i) && out_addr_i != `HSK_OFS;

  msg_byte_store #(.WIDTH(8), .DEPTH(16), .AW(4)) u_cmd_store (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .wr_en_i(cmd_wr),
    .wr_addr_i(out_addr_i[3:0]),
    .wr_data_i(out_data_i),
    .rd_addr_i(s.idx),
    .rd_data_o(cmd_rd_data)
  );

  // response store also holds the handshake byte in its last slot, rewritten every cycle except in ST_RECV
  msg_byte_store #(.WIDTH(8), .DEPTH(16), .AW(4)) u_resp_store (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .wr_en_i(resp_wr),
    .wr_addr_i(resp_addr),
    .wr_data_i(resp_data),
    .rd_addr_i(in_addr_i[3:0]),
    .rd_data_o(in_data_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  // toggle reads as zero while the clear bit is held
  assign hs_eff = s.clear ? 1'b0 : s.handshake_toggle_out;
  assign nwords = s.cmd[3][3:1];
  assign fc_ok = (s.cmd[0] == `FC_READ) || (s.cmd[0] == `FC_WRITE);
  assign cnt_ok = !s.cmd[3][0] && nwords != 3'h0 && nwords <= 3'h4 && s.cmd[3][7:4] == 4'h0;

  always_comb begin
    n = s;
    resp_wr = 1'b1;
    resp_addr = `HSK_IDX;
    // handshake byte echoes the last completed toggle, so it tracks history
    resp_data = {s.handshake_toggle_in, status_of(s.state), s.alive_counter, 1'b0};

    // free-running alive counter, wraps after 15
    if (s.tick >= 32'(ALIVE_TICKS - 1)) begin
      n.tick = '0;
      n.alive_counter = s.alive_counter + 4'h1;
    end else begin
      n.tick = s.tick + 32'h1;
    end

    // handshake output byte: bit 7 toggle, bit 0 clear, bits 1 to 6 dropped
    if (out_wr_i && out_addr_i == `HSK_OFS) begin
      n.handshake_toggle_out = out_data_i[`HSK_TOGGLE_BIT];
      n.clear = out_data_i[`HSK_CLEAR_BIT];
      if (s.clear && !out_data_i[`HSK_CLEAR_BIT]) begin
        n.handshake_toggle_in = 1'b0;
      end
    end

    case (s.state)
      fieldbus_message_handshake_pkg::ST_IDLE: begin
        if (hs_eff != s.toggle_seen) begin
          n.toggle_seen = hs_eff;
          n.err = 1'b0;
          n.err_code = 8'h00;
          n.rd_words = '0;
          n.idx = 4'h0;
          n.word = 2'h0;
          n.state = fieldbus_message_handshake_pkg::ST_FETCH;
        end
      end
      fieldbus_message_handshake_pkg::ST_FETCH: begin
        // store read has one cycle of latency, so byte idx-1 arrives now
        if (s.idx != 4'h0) begin
          n.cmd[s.idx - 4'h1] = cmd_rd_data;
        end
        if (s.idx == `CMD_LEN) begin
          if (!fc_ok || !cnt_ok) begin
            n.err = 1'b1;
            n.err_code = !fc_ok ? `ERR_CODE_FUNC : `ERR_CODE_COUNT;
            n.idx = 4'h0;
            n.state = fieldbus_message_handshake_pkg::ST_RECV;
          end else begin
            n.state = fieldbus_message_handshake_pkg::ST_SEND;
          end
        end else begin
          n.idx = s.idx + 4'h1;
        end
      end
      fieldbus_message_handshake_pkg::ST_SEND: begin
        // values pass through untouched: raw binary, two's complement kept
        n.drv_req = 1'b1;
        n.drv_write = (s.cmd[0] == `FC_WRITE);
        n.drv_reg = {s.cmd[1], s.cmd[2]} + {14'h0, s.word};
        n.drv_wdata = {s.cmd[4'(4'h4 + {s.word, 1'b0})], s.cmd[4'(4'h5 + {s.word, 1'b0})]};
        n.state = fieldbus_message_handshake_pkg::ST_WAIT;
      end
      fieldbus_message_handshake_pkg::ST_WAIT: begin
        if (drv_ack_i) begin
          n.drv_req = 1'b0;
          n.idx = 4'h0;
          if (drv_err_i) begin
            n.err = 1'b1;
            n.err_code = drv_err_code_i;
            n.state = fieldbus_message_handshake_pkg::ST_RECV;
          end else begin
            n.rd_words[s.word] = s.drv_write ? 16'h0000 : drv_rdata_i;
            if ({1'b0, s.word} == nwords - 3'h1) begin
              n.state = fieldbus_message_handshake_pkg::ST_RECV;
            end else begin
              n.word = s.word + 2'h1;
              n.state = fieldbus_message_handshake_pkg::ST_SEND;
            end
          end
        end
      end
      fieldbus_message_handshake_pkg::ST_RECV: begin
        // fill response bytes before the toggle is mirrored
        resp_addr = s.idx;
        resp_data = resp_byte(s, s.idx);
        if (s.idx == `RESP_LAST_IDX) begin
          n.state = fieldbus_message_handshake_pkg::ST_DONE;
        end else begin
          n.idx = s.idx + 4'h1;
        end
      end
      fieldbus_message_handshake_pkg::ST_DONE: begin
        n.handshake_toggle_in = s.toggle_seen;
        n.state = fieldbus_message_handshake_pkg::ST_IDLE;
      end
      default: begin
        n.state = fieldbus_message_handshake_pkg::ST_IDLE;
      end
    endcase

    // clear held: abandon any exchange and rest toggle_seen at zero; the echoed toggle clears on release
    if (n.clear) begin
      n.toggle_seen = 1'b0;
      n.drv_req = 1'b0;
      n.state = fieldbus_message_handshake_pkg::ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
      s.state <= fieldbus_message_handshake_pkg::ST_IDLE;
    end else begin
      s <= n;
    end
  end

  // drive port straight from the state flops
  assign drv_req_o = s.drv_req;
  assign drv_write_o = s.drv_write;
  assign drv_reg_o = s.drv_reg;
  assign drv_wdata_o = s.drv_wdata;

endmodule

// ---- tb/fieldbus_message_handshake_chk.sv ----
// assertions on the message handshake ports
`timescale 1ns/1ps
module fieldbus_message_handshake_chk (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // cyclic images
  input wire logic out_wr_i,
  input wire logic [4:0] out_addr_i,
  input wire logic [7:0] out_data_i,
  input wire logic [4:0] in_addr_i,
  input wire logic [7:0] in_data_o,
  // drive port
  input wire logic drv_req_o,
  input wire logic [15:0] drv_reg_o,
  input wire logic drv_ack_i
);
  logic tog;
  logic clr;
  logic clr_wr;
  // clear written this cycle: the request falls at once, before clr shows it
  assign clr_wr = out_wr_i && out_addr_i == 5'h1f && out_data_i[0];
  // toggle as the master last set it; clear makes it count as low
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tog <= 1'b0;
      clr <= 1'b0;
    end else if (out_wr_i && out_addr_i == 5'h1f) begin
      tog <= out_data_i[7] & ~out_data_i[0];
      clr <= out_data_i[0];
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // an abort is ignored so the busy checks do not trip on it
  sequence tog_wr;
    out_wr_i && out_addr_i == 5'h1f && !out_data_i[0] && !clr && out_data_i[7] != tog;
  endsequence
  sequence busy_rd;
    (drv_req_o && !clr)[*3] ##0 in_addr_i == 5'h1f;
  endsequence
  ////////////////////////////////////////
  req_hold_a: assert property (drv_req_o && !drv_ack_i && !clr && !clr_wr |=> drv_req_o)
    else $error("request dropped before ack");
  req_stable_a: assert property (drv_req_o && !drv_ack_i && !clr |=> $stable(drv_reg_o))
    else $error("register number moved while waiting");
  req_drop_a: assert property (drv_req_o && drv_ack_i |=> !drv_req_o)
    else $error("request still high after ack");
  cmd_start_a: assert property (tog_wr ##2 (in_addr_i == 5'h1f)[*6] |=> in_data_o[6:5] == 2'b01)
    else $error("toggle change did not start sending");
  wait_status_a: assert property (busy_rd |=> in_data_o[6:5] == 2'b10)
    else $error("status not awaiting while request open");
  toggle_busy_a: assert property (busy_rd |=> in_data_o[7] != tog)
    else $error("toggle echoed before response complete");
  alive_step_a: assert property (in_addr_i == 5'h1f ##1 in_addr_i == 5'h1f |=>
    in_data_o[4:1] == $past(in_data_o[4:1]) || in_data_o[4:1] == $past(in_data_o[4:1]) + 4'h1)
    else $error("alive counter jumped");
  clear_abort_a: assert property (out_wr_i && out_addr_i == 5'h1f && out_data_i[0] |-> ##3 (!drv_req_o)[*8])
    else $error("clear did not stop the exchange");
endmodule

// ---- tb/drive_model.sv ----
// drive side model answering register accesses after a set delay
`timescale 1ns/1ps
module drive_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // access from the block
  input wire logic req_i,
  input wire logic [15:0] reg_i,
  // bench knobs: answer delay and failing register
  input wire logic [3:0] slow_i,
  input wire logic [15:0] bad_reg_i,
  // answer
  output logic ack_o,
  output logic err_o,
  output logic [7:0] err_code_o,
  output logic [15:0] rdata_o
);
  logic [3:0] cnt;
  // one-cycle ack after slow_i idle cycles
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_o <= 1'b0;
      cnt <= 4'h0;
    end else if (ack_o || !req_i) begin
      ack_o <= 1'b0;
      cnt <= 4'h0;
    end else if (cnt == slow_i) begin
      ack_o <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  // raw integer values; outside ack the fields keep moving so stale use shows
  assign err_o = ack_o ? reg_i == bad_reg_i : cnt[0];
  assign err_code_o = ack_o ? reg_i[7:0] ^ 8'h3c : {2{cnt}};
  assign rdata_o = ack_o ? reg_i ^ 16'h5a5a : {4{cnt}};
endmodule

// ---- tb/test_fieldbus_message_handshake.sv ----
// self-checking bench for the message handshake block
`timescale 1ns/1ps
module test_fieldbus_message_handshake;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic out_wr_i = 1'b0;
  logic [4:0] out_addr_i = 5'h00;
  logic [7:0] out_data_i = 8'h00;
  logic [4:0] in_addr_i = 5'h00;
  logic [7:0] in_data_o, drv_err_code_i, d, d0;
  logic drv_req_o, drv_write_o, drv_ack_i, drv_err_i;
  logic [15:0] drv_reg_o, drv_wdata_o, drv_rdata_i;
  logic [3:0] slow = 4'h0;
  logic [15:0] bad = 16'h0000;
  logic tog = 1'b0;
  logic [31:0] rnd = 32'h4cd4;
  logic [7:0] exp_b [15];
  logic [32:0] q [$];
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  fieldbus_message_handshake #(.ALIVE_TICKS(20)) dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .out_wr_i(out_wr_i), .out_addr_i(out_addr_i), .out_data_i(out_data_i), .in_addr_i(in_addr_i),
    .in_data_o(in_data_o), .drv_req_o(drv_req_o), .drv_write_o(drv_write_o), .drv_reg_o(drv_reg_o),
    .drv_wdata_o(drv_wdata_o), .drv_ack_i(drv_ack_i), .drv_err_i(drv_err_i),
    .drv_err_code_i(drv_err_code_i), .drv_rdata_i(drv_rdata_i));
  drive_model drv (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req_i(drv_req_o), .reg_i(drv_reg_o),
    .slow_i(slow), .bad_reg_i(bad), .ack_o(drv_ack_i), .err_o(drv_err_i), .err_code_o(drv_err_code_i),
    .rdata_o(drv_rdata_i));
  always #5 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk_byte(logic [7:0] e, logic [7:0] g);
    checks++;
    if (e !== g) begin
      miscompares++;
      $display("ERROR byte expected %h seen %h", e, g);
    end
  endtask
  task automatic chk_acc(logic [32:0] e, logic [32:0] g);
    checks++;
    if (e !== g) begin
      miscompares++;
      $display("ERROR access expected %h seen %h", e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // master side byte cycles, changed only at the falling edge
  task automatic wr(logic [4:0] a, logic [7:0] v);
    @(negedge clk_sys_i);
    out_wr_i = 1'b1;
    out_addr_i = a;
    out_data_i = v;
    @(negedge clk_sys_i);
    out_wr_i = 1'b0;
  endtask
  task automatic rd(logic [4:0] a, output logic [7:0] v);
    @(negedge clk_sys_i);
    in_addr_i = a;
    @(negedge clk_sys_i);
    v = in_data_o;
  endtask
  ////////////////////////////////////////
  // every finished drive access must be the next one the message asks for
  always @(negedge clk_sys_i) begin
    if (drv_req_o && drv_ack_i) begin
      chk_acc(q.size() > 0 ? q.pop_front() : 33'h0, {drv_write_o, drv_reg_o, drv_write_o ? drv_wdata_o : 16'h0});
    end
  end
  // hang guard, far above the longest expected run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  // one message: fill bytes, toggle, await echo, compare response with the reference
  task automatic cmd(logic [7:0] fc, logic [7:0] cnt, int eb, logic ab);
    logic [7:0] b [12];
    logic [7:0] code;
    logic [15:0] r;
    logic [15:0] a;
    code = 8'h00;
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      b[i] = rnd[7:0];
    end
    b[0] = fc;
    b[3] = cnt;
    r = {b[1], b[2]};
    bad = r + 16'(eb);
    foreach (exp_b[i]) exp_b[i] = 8'h00;
    if (fc != 8'h03 && fc != 8'h10) code = 8'h01;
    else if (cnt > 8'h08 || cnt == 8'h00 || cnt[0]) code = 8'h03;
    else for (int k = 0; k < cnt / 2 && code == 8'h00; k++) begin
      a = r + 16'(k);
      q.push_back({fc == 8'h10, a, fc == 8'h10 ? {b[4 + 2 * k], b[5 + 2 * k]} : 16'h0});
      if (a == bad) code = a[7:0] ^ 8'h3c;
      else if (fc == 8'h03) {exp_b[4 + 2 * k], exp_b[5 + 2 * k]} = a ^ 16'h5a5a;
    end
    if (code != 8'h00) begin
      foreach (exp_b[i]) exp_b[i] = 8'h00;
      exp_b[0] = fc | 8'h80;
      exp_b[3] = 8'h02;
      exp_b[5] = code;
    end else begin
      exp_b[0] = fc;
      exp_b[1] = b[1];
      exp_b[2] = b[2];
      exp_b[3] = cnt;
    end
    for (int i = 0; i < 12; i++) wr(5'h10 + 5'(i), b[i]);
    tog = ~tog;
    wr(5'h1f, {tog, rnd[14:9], 1'b0});
    if (ab) begin
      repeat (20) @(negedge clk_sys_i);
      wr(5'h1f, 8'h81);
      rd(5'h1f, d);
      rd(5'h1f, d);
      chk_byte(8'h80, {d[7:5], 5'h00});
      wr(5'h1f, 8'h00);
      rd(5'h1f, d);
      rd(5'h1f, d);
      chk_byte(8'h00, {d[7:5], 5'h00});
      tog = 1'b0;
      q.delete();
      return;
    end
    d = {~tog, 7'h00};
    for (int i = 0; i < 300 && d[7] !== tog; i++) rd(5'h1f, d);
    chk_byte({5'h00, tog, 2'b00}, {5'h00, d[7:5]});
    for (int i = 0; i < 15; i++) begin
      rd(5'h10 + 5'(i), d);
      chk_byte(exp_b[i], d);
    end
    chk_acc(33'h0, 33'(q.size()));
  endtask
  initial begin
    repeat (16) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    rd(5'h1f, d);
    rd(5'h1f, d);
    chk_byte(8'h00, {d[7:5], 4'h0, d[0]});
    cmd(8'h03, 8'h08, 15, 1'b0);
    slow = 4'h3;
    cmd(8'h10, 8'h02, 15, 1'b0);
    cmd(8'h10, 8'h04, 1, 1'b0);
    cmd(8'h03, 8'h06, 2, 1'b0);
    cmd(8'h05, 8'h02, 15, 1'b0);
    cmd(8'h03, 8'h03, 15, 1'b0);
    // read failing on its first word; also leaves the echoed toggle high before the abort
    cmd(8'h03, 8'h04, 0, 1'b0);
    slow = 4'hf;
    cmd(8'h03, 8'h02, 15, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      slow = rnd[6:3];
      cmd(rnd[0] ? 8'h10 : 8'h03, {5'h00, rnd[2:1], 1'b0} + 8'h02, 15, 1'b0);
    end
    rd(5'h1f, d0);
    repeat (18) @(negedge clk_sys_i);
    rd(5'h1f, d);
    chk_byte({4'h0, d0[4:1] + 4'h1}, {4'h0, d[4:1]});
    repeat (298) @(negedge clk_sys_i);
    rd(5'h1f, d);
    chk_byte({4'h0, d0[4:1]}, {4'h0, d[4:1]});
    conclude();
  end
endmodule
bind fieldbus_message_handshake fieldbus_message_handshake_chk chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
  .out_wr_i(out_wr_i), .out_addr_i(out_addr_i), .out_data_i(out_data_i), .in_addr_i(in_addr_i),
  .in_data_o(in_data_o), .drv_req_o(drv_req_o), .drv_reg_o(drv_reg_o), .drv_ack_i(drv_ack_i));
